// ---- ths_splitter.v ----
// Two-head parallel data path, head mapping, sequencing and status
`timescale 1ns/1ps
`include "ths_defs.vh"

// Notes on behaviour
// - Channel 0 serves head arms one to five
// - Channel 1 serves head arms six to ten
// - Logical head zero: heads 17 and 7
// - Exactly one of three interleave modes
// - Bit write: odd bits ch0, even ch1
// - Bit read: odd from ch0, even ch1
// - Byte write: even bytes ch0, odd ch1
// - Byte read: even from ch0, odd ch1
// - Word write: even words ch0, odd ch1
// - Word read: even from ch0, odd ch1
// - Signal each track start to controller
// - Fault drives controller signal and indicator
// - Errors and faults go in status
module ths_splitter (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        cmd_valid,
	input  wire [2:0]  cmd_code,
	input  wire [11:0] cmd_arg,
	input  wire [1:0]  cmd_mode,
	output reg         sts_valid,
	output reg  [7:0]  sts_code,
	input  wire        wr_valid,
	input  wire [15:0] wr_data,
	output reg         wr_ready,
	output reg         rd_valid,
	output reg  [15:0] rd_data,
	output reg         ch_wr_valid,
	output reg  [15:0] ch0_wr_data,
	output reg  [15:0] ch1_wr_data,
	output reg         ch_write_gate,
	output reg         ch_read_gate,
	input  wire        ch0_rd_valid,
	input  wire [15:0] ch0_rd_data,
	input  wire        ch1_rd_valid,
	input  wire [15:0] ch1_rd_data,
	output reg  [11:0] cylinder,
	output reg  [4:0]  ch0_head,
	output reg  [3:0]  ch0_arm,
	output reg  [4:0]  ch1_head,
	output reg  [3:0]  ch1_arm,
	output reg         head_upper,
	input  wire        index_pin,
	output reg         track_start,
	input  wire        fault_pin,
	output reg         fault_out,
	output reg         fault_led
);

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam ST_IDLE  = 3'h0;
	localparam ST_SEEK  = 3'h1;
	localparam ST_READY = 3'h2;
	localparam ST_WRITE = 3'h3;
	localparam ST_READ  = 3'h4;

	reg [2:0]  state_reg;
	reg [1:0]  mode_reg;
	reg [15:0] half_reg;
	reg        half_pending_reg;
	reg [15:0] rd_hold_reg;
	reg        rd_hold_pending_reg;
	reg [7:0]  err_reg;
	reg [7:0]  err_next;
	reg        fault_reg;
	reg [1:0]  index_sync_reg;
	reg        index_last_reg;
	reg [1:0]  fault_sync_reg;
	reg [7:0]  resp_next;

	wire [15:0] map_ch0;
	wire [15:0] map_ch1;
	wire [15:0] map_w0;
	wire [15:0] map_w1;

	// Flush of an odd last word pads the second half with zeros
	wire [15:0] pair_w1 = (wr_valid && wr_ready && half_pending_reg) ? wr_data : 16'h0000;
	wire        take_wr = wr_valid && wr_ready;
	wire        both_rd = ch0_rd_valid && ch1_rd_valid;
	wire        one_rd  = ch0_rd_valid ^ ch1_rd_valid;
	wire        end_cmd = cmd_valid && (cmd_code == `THS_CMD_END);

	ths_lane_map u_map (
		.mode     (mode_reg),
		.host_w0  (half_reg),
		.host_w1  (pair_w1),
		.ch0_in   (ch0_rd_data),
		.ch1_in   (ch1_rd_data),
		.ch0_out  (map_ch0),
		.ch1_out  (map_ch1),
		.merge_w0 (map_w0),
		.merge_w1 (map_w1)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			index_sync_reg <= 2'h0;
			index_last_reg <= 1'b0;
			fault_sync_reg <= 2'h0;
			track_start    <= 1'b0;
		end else begin
			index_sync_reg <= {index_sync_reg[0], index_pin};
			fault_sync_reg <= {fault_sync_reg[0], fault_pin};
			index_last_reg <= index_sync_reg[1];
			track_start    <= index_sync_reg[1] && !index_last_reg;
		end
	end

	// ----------------------------------------
	// Error gathering and command response
	// ----------------------------------------
	always @* begin
		err_next = err_reg;
		if (state_reg == ST_READ && one_rd) begin
			err_next[`THS_STS_ALIGN] = 1'b1;
		end
		if (state_reg == ST_READ && both_rd && rd_hold_pending_reg) begin
			err_next[`THS_STS_OVERRUN] = 1'b1;
		end
		if (end_cmd && half_pending_reg && state_reg == ST_WRITE) begin
			err_next[`THS_STS_ODD] = 1'b1;
		end
		err_next[`THS_STS_FAULT] = fault_reg;
		resp_next = 8'h00;
		case (cmd_code)
			`THS_CMD_SEEK: begin
				resp_next[`THS_STS_ORDER] = (state_reg == ST_WRITE) || (state_reg == ST_READ);
			end
			`THS_CMD_HEAD: begin
				resp_next[`THS_STS_ORDER] = (state_reg != ST_SEEK) && (state_reg != ST_READY);
				resp_next[`THS_STS_RANGE] = cmd_arg[3:0] > `THS_LHEAD_MAX;
			end
			`THS_CMD_WRITE, `THS_CMD_READ: begin
				resp_next[`THS_STS_ORDER] = state_reg != ST_READY;
				resp_next[`THS_STS_MODE]  = cmd_mode == 2'h3;
			end
			`THS_CMD_END: begin
				resp_next = err_next;
				resp_next[`THS_STS_ORDER] = (state_reg != ST_WRITE) && (state_reg != ST_READ);
			end
			default: begin
				resp_next = 8'h00;
			end
		endcase
		resp_next[`THS_STS_FAULT] = fault_reg;
		resp_next[`THS_STS_OK]    = (resp_next[7:1] == 7'h00);
	end

	// ----------------------------------------
	// Sequencer, head mapping and data path
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg           <= ST_IDLE;
			mode_reg            <= `THS_MODE_BIT;
			half_reg            <= 16'h0000;
			half_pending_reg    <= 1'b0;
			rd_hold_reg         <= 16'h0000;
			rd_hold_pending_reg <= 1'b0;
			err_reg             <= 8'h00;
			fault_reg           <= 1'b0;
			sts_valid           <= 1'b0;
			sts_code            <= 8'h00;
			wr_ready            <= 1'b0;
			rd_valid            <= 1'b0;
			rd_data             <= 16'h0000;
			ch_wr_valid         <= 1'b0;
			ch0_wr_data         <= 16'h0000;
			ch1_wr_data         <= 16'h0000;
			ch_write_gate       <= 1'b0;
			ch_read_gate        <= 1'b0;
			cylinder            <= 12'h000;
			ch0_head            <= `THS_CH0_HEAD0;
			ch0_arm             <= `THS_CH0_ARM0;
			ch1_head            <= `THS_CH1_HEAD0;
			ch1_arm             <= `THS_CH1_ARM0;
			head_upper          <= 1'b0;
			fault_out           <= 1'b0;
			fault_led           <= 1'b0;
		end else begin
			sts_valid   <= 1'b0;
			ch_wr_valid <= 1'b0;
			rd_valid    <= 1'b0;
			err_reg     <= err_next;
			// Fault stays until a clear; a fault present at the clear wins
			if (fault_sync_reg[1]) begin
				fault_reg <= 1'b1;
			end else if (cmd_valid && cmd_code == `THS_CMD_CLEAR) begin
				fault_reg <= 1'b0;
			end
			fault_out <= fault_reg;
			fault_led <= fault_reg;

			// Write pairing: two host words feed one word to each channel
			if (state_reg == ST_WRITE && take_wr) begin
				if (!half_pending_reg) begin
					half_reg         <= wr_data;
					half_pending_reg <= 1'b1;
				end else begin
					half_pending_reg <= 1'b0;
					ch_wr_valid      <= 1'b1;
					ch0_wr_data      <= map_ch0;
					ch1_wr_data      <= map_ch1;
				end
			end

			// Read merge: only an aligned pair is accepted
			if (state_reg == ST_READ) begin
				if (rd_hold_pending_reg) begin
					rd_valid            <= 1'b1;
					rd_data             <= rd_hold_reg;
					rd_hold_pending_reg <= 1'b0;
				end else if (both_rd) begin
					rd_valid            <= 1'b1;
					rd_data             <= map_w0;
					rd_hold_reg         <= map_w1;
					rd_hold_pending_reg <= 1'b1;
				end
			end

			if (cmd_valid) begin
				sts_valid <= 1'b1;
				sts_code  <= resp_next;
				// An end with error bits still closes the transfer, so a fault cannot lock it open
				if (resp_next[`THS_STS_OK] || (cmd_code == `THS_CMD_END && !resp_next[`THS_STS_ORDER])) begin
					case (cmd_code)
						`THS_CMD_SEEK: begin
							cylinder  <= cmd_arg;
							state_reg <= ST_SEEK;
						end
						`THS_CMD_HEAD: begin
							ch0_head   <= `THS_CH0_HEAD0 - {1'b0, cmd_arg[3:0]};
							ch1_head   <= (cmd_arg[3:0] == `THS_LHEAD_MAX) ? `THS_CH1_HEAD_LAST :
								`THS_CH1_HEAD0 - {1'b0, cmd_arg[3:0]};
							ch0_arm    <= `THS_CH0_ARM0 - {1'b0, cmd_arg[3:1]};
							ch1_arm    <= `THS_CH1_ARM0 - {1'b0, cmd_arg[3:1]};
							head_upper <= cmd_arg[0];
							state_reg  <= ST_READY;
						end
						`THS_CMD_WRITE: begin
							mode_reg      <= cmd_mode;
							wr_ready      <= 1'b1;
							ch_write_gate <= 1'b1;
							state_reg     <= ST_WRITE;
						end
						`THS_CMD_READ: begin
							mode_reg     <= cmd_mode;
							ch_read_gate <= 1'b1;
							state_reg    <= ST_READ;
						end
						`THS_CMD_END: begin
							if (half_pending_reg && state_reg == ST_WRITE) begin
								ch_wr_valid <= 1'b1;
								ch0_wr_data <= map_ch0;
								ch1_wr_data <= map_ch1;
							end
							half_pending_reg    <= 1'b0;
							rd_hold_pending_reg <= 1'b0;
							err_reg             <= 8'h00;
							wr_ready         <= 1'b0;
							ch_write_gate    <= 1'b0;
							ch_read_gate     <= 1'b0;
							state_reg        <= ST_READY;
						end
						default: begin
							state_reg <= state_reg;
						end
					endcase
				end
			end
		end
	end

endmodule

// ---- ths_defs.vh ----
// Constants for the two-head interleave splitter
`ifndef THS_DEFS_VH
`define THS_DEFS_VH

// ----------------------------------------
// Interleave modes
// ----------------------------------------
`define THS_MODE_BIT       2'h0
`define THS_MODE_BYTE      2'h1
`define THS_MODE_WORD      2'h2

// ----------------------------------------
// Host command codes
// ----------------------------------------
`define THS_CMD_SEEK       3'h0
`define THS_CMD_HEAD       3'h1
`define THS_CMD_WRITE      3'h2
`define THS_CMD_READ       3'h3
`define THS_CMD_END        3'h4
`define THS_CMD_CLEAR      3'h5

// ----------------------------------------
// Status response bit positions
// ----------------------------------------
`define THS_STS_OK         0
`define THS_STS_ORDER      1
`define THS_STS_MODE       2
`define THS_STS_ALIGN      3
`define THS_STS_OVERRUN    4
`define THS_STS_FAULT      5
`define THS_STS_ODD        6
`define THS_STS_RANGE      7

// ----------------------------------------
// Head mapping
// ----------------------------------------
`define THS_LHEAD_MAX      4'h8
`define THS_CH0_HEAD0      5'h11
`define THS_CH1_HEAD0      5'h07
`define THS_CH1_HEAD_LAST  5'h08
`define THS_CH0_ARM0       4'h5
`define THS_CH1_ARM0       4'hA

`endif

// ---- ths_lane_map.v ----
// Interleave split and merge of a two-word group across both channels
`timescale 1ns/1ps
`include "ths_defs.vh"

module ths_lane_map (
	input  wire [1:0]  mode,
	input  wire [15:0] host_w0,
	input  wire [15:0] host_w1,
	input  wire [15:0] ch0_in,
	input  wire [15:0] ch1_in,
	output reg  [15:0] ch0_out,
	output reg  [15:0] ch1_out,
	output reg  [15:0] merge_w0,
	output reg  [15:0] merge_w1
);

	// ----------------------------------------
	// Bit helpers, MSB first
	// ----------------------------------------
	function [15:0] pick_bits;
		input [31:0] s;
		input        second;
		integer      i;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				pick_bits[15 - i] = second ? s[30 - 2 * i] : s[31 - 2 * i];
			end
		end
	endfunction

	function [31:0] weave;
		input [15:0] a;
		input [15:0] b;
		integer      i;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				weave[31 - 2 * i] = a[15 - i];
				weave[30 - 2 * i] = b[15 - i];
			end
		end
	endfunction

	reg [31:0] woven;

	// ----------------------------------------
	// Mapping
	// ----------------------------------------
	always @* begin
		woven = weave(ch0_in, ch1_in);
		case (mode)
			`THS_MODE_BIT: begin
				ch0_out  = pick_bits({host_w0, host_w1}, 1'b0);
				ch1_out  = pick_bits({host_w0, host_w1}, 1'b1);
				merge_w0 = woven[31:16];
				merge_w1 = woven[15:0];
			end
			`THS_MODE_BYTE: begin
				ch0_out  = {host_w0[15:8], host_w1[15:8]};
				ch1_out  = {host_w0[7:0], host_w1[7:0]};
				merge_w0 = {ch0_in[15:8], ch1_in[15:8]};
				merge_w1 = {ch0_in[7:0], ch1_in[7:0]};
			end
			default: begin
				ch0_out  = host_w0;
				ch1_out  = host_w1;
				merge_w0 = ch0_in;
				merge_w1 = ch1_in;
			end
		endcase
	end

endmodule

// ---- ths_splitter_assertions.sv ----
// Port checker for the two-head splitter
`timescale 1ns/1ps
module ths_splitter_assertions (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        cmd_valid,
	input wire logic [2:0]  cmd_code,
	input wire logic [11:0] cmd_arg,
	input wire logic [1:0]  cmd_mode,
	input wire logic        sts_valid,
	input wire logic [7:0]  sts_code,
	input wire logic        rd_valid,
	input wire logic        ch_wr_valid,
	input wire logic        ch_write_gate,
	input wire logic        ch_read_gate,
	input wire logic        ch0_rd_valid,
	input wire logic        ch1_rd_valid,
	input wire logic [4:0]  ch0_head,
	input wire logic [3:0]  ch0_arm,
	input wire logic [4:0]  ch1_head,
	input wire logic [3:0]  ch1_arm,
	input wire logic        track_start,
	input wire logic        fault_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----
	// Assertions
	// ----
	a_cmd_answer: assert property (cmd_valid |=> sts_valid)
		else $error("no status after command");
	a_sts_cause: assert property (sts_valid |-> $past(cmd_valid))
		else $error("status without command");
	a_head0_map: assert property (sts_valid && sts_code[0] && $past(cmd_code) == 3'h1
		&& $past(cmd_arg[3:0]) == 4'h0 |-> {ch0_head, ch1_head, ch0_arm, ch1_arm} == {5'h11, 5'h07, 4'h5, 4'hA})
		else $error("logical head zero map wrong");
	a_ch0_arms: assert property (ch0_arm >= 4'h1 && ch0_arm <= 4'h5)
		else $error("channel 0 arm out of range");
	a_ch1_arms: assert property (ch1_arm >= 4'h6 && ch1_arm <= 4'hA)
		else $error("channel 1 arm out of range");
	a_bad_mode: assert property (cmd_valid && cmd_code[2:1] == 2'h1 && cmd_mode == 2'h3
		|=> sts_code[2] && !sts_code[0])
		else $error("mode three accepted");
	a_read_merge: assert property (ch_read_gate && ch0_rd_valid && ch1_rd_valid
		|=> rd_valid ##1 rd_valid)
		else $error("channel pair not merged");
	a_gates_excl: assert property (!(ch_write_gate && ch_read_gate))
		else $error("both gates high");
	a_track_pulse: assert property (track_start |=> !track_start)
		else $error("track start too long");
	a_fault_hold: assert property (fault_out && !(cmd_valid && cmd_code == 3'h5)
		&& !($past(cmd_valid) && $past(cmd_code) == 3'h5) |=> fault_out)
		else $error("fault dropped");
	a_fault_sts: assert property (sts_valid && fault_out && $past(fault_out) |-> sts_code[5])
		else $error("fault missing in status");
	cover property (ch_wr_valid);
	cover property (rd_valid ##1 rd_valid);
	cover property (track_start);
	cover property (fault_out);
endmodule

bind ths_splitter ths_splitter_assertions u_chk (
	.ref_clk, .rst, .cmd_valid, .cmd_code, .cmd_arg, .cmd_mode, .sts_valid, .sts_code,
	.rd_valid, .ch_wr_valid, .ch_write_gate, .ch_read_gate, .ch0_rd_valid, .ch1_rd_valid,
	.ch0_head, .ch0_arm, .ch1_head, .ch1_arm, .track_start, .fault_out
);

// ---- ths_host_model.sv ----
// Host controller model: commands and write words
`timescale 1ns/1ps
module ths_host_model (
	input  wire logic        ref_clk,
	input  wire logic [7:0]  sts_code,
	output logic             cmd_valid,
	output logic      [2:0]  cmd_code,
	output logic      [11:0] cmd_arg,
	output logic      [1:0]  cmd_mode,
	output logic             wr_valid,
	output logic      [15:0] wr_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 3'h0;
		cmd_arg = 12'h000;
		cmd_mode = 2'h0;
		wr_valid = 1'b0;
		wr_data = 16'h0000;
	end
	// Idle argument and data lines show the inverse so stale values never pass
	task automatic cmd(input logic [2:0] c, input logic [11:0] a, input logic [1:0] m, output logic [7:0] s);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_arg <= a;
		cmd_mode <= m;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		cmd_arg <= ~a;
		#1 s = sts_code;
	endtask
	// Seek first, then head select
	task automatic setup(input logic [11:0] cyl, input logic [3:0] lh, output logic [7:0] s);
		cmd(3'h0, cyl, 2'h0, s);
		cmd(3'h1, {8'h00, lh}, 2'h0, s);
	endtask
	task automatic pair(input logic [15:0] w0, input logic [15:0] w1);
		@(posedge ref_clk);
		wr_valid <= 1'b1;
		wr_data <= w0;
		@(posedge ref_clk);
		wr_data <= w1;
		@(posedge ref_clk);
		wr_valid <= 1'b0;
		wr_data <= ~w1;
		#1;
	endtask
	task automatic single(input logic [15:0] w);
		@(posedge ref_clk);
		wr_valid <= 1'b1;
		wr_data <= w;
		@(posedge ref_clk);
		wr_valid <= 1'b0;
		wr_data <= ~w;
		#1;
	endtask
endmodule

// ---- ths_splitter_tb.sv ----
// Testbench for the two-head splitter
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED at %0t: got %0h exp %0h", $time, a, e); end end
module ths_splitter_tb;
	logic        ref_clk, rst, cmd_valid, sts_valid, wr_valid, wr_ready, rd_valid, ch_wr_valid;
	logic        ch_write_gate, ch_read_gate, ch0_rd_valid, ch1_rd_valid, head_upper;
	logic        index_pin, track_start, fault_pin, fault_out, fault_led;
	logic [1:0]  cmd_mode;
	logic [2:0]  cmd_code;
	logic [3:0]  ch0_arm, ch1_arm;
	logic [4:0]  ch0_head, ch1_head;
	logic [7:0]  sts_code, s;
	logic [11:0] cmd_arg, cylinder;
	logic [15:0] wr_data, rd_data, ch0_wr_data, ch1_wr_data, ch0_rd_data, ch1_rd_data;
	int          fails, checks_done;

	ths_splitter u_dut (
		.ref_clk, .rst, .cmd_valid, .cmd_code, .cmd_arg, .cmd_mode, .sts_valid, .sts_code,
		.wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data, .ch_wr_valid, .ch0_wr_data,
		.ch1_wr_data, .ch_write_gate, .ch_read_gate, .ch0_rd_valid, .ch0_rd_data, .ch1_rd_valid,
		.ch1_rd_data, .cylinder, .ch0_head, .ch0_arm, .ch1_head, .ch1_arm, .head_upper,
		.index_pin, .track_start, .fault_pin, .fault_out, .fault_led
	);
	ths_host_model u_host (
		.ref_clk, .sts_code, .cmd_valid, .cmd_code, .cmd_arg, .cmd_mode, .wr_valid, .wr_data
	);

	// ----
	// Helpers
	// ----
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task issue(input logic [2:0] c, input logic [1:0] m);
		u_host.cmd(c, 12'h000, m, s);
		`CHK(sts_valid, 1'b1)
	endtask

	// ----
	// Scenarios
	// ----
	task t_refuse;
		issue(3'h1, 2'h0);
		`CHK(s[1:0], 2'h2)
		u_host.setup(12'h7FF, 4'h9, s);
		`CHK(s[7], 1'b1)
		u_host.setup(12'h7FF, 4'h8, s);
		`CHK({ch0_head, ch1_head, ch0_arm, ch1_arm}, {5'h09, 5'h08, 4'h1, 4'h6})
		u_host.cmd(3'h1, 12'h003, 2'h0, s);
		`CHK({cylinder, ch0_head, ch1_head, ch0_arm, ch1_arm, head_upper}, {12'h7FF, 5'h0E, 5'h04, 4'h4, 4'h9, 1'b1})
		issue(3'h1, 2'h0);
		`CHK({ch0_head, ch1_head, ch0_arm, ch1_arm}, {5'h11, 5'h07, 4'h5, 4'hA})
		issue(3'h2, 2'h3);
		`CHK({s[2:0], ch_write_gate}, 4'h8)
		$display("test refuse over");
	endtask
	task t_xfer(input logic [1:0] m, input logic [15:0] w0, w1, c0, c1);
		u_host.setup(12'h123, 4'h0, s);
		issue(3'h2, m);
		`CHK({wr_ready, ch_write_gate, ch_read_gate}, 3'h6)
		u_host.pair(w0, w1);
		`CHK({ch_wr_valid, ch0_wr_data, ch1_wr_data}, {1'b1, c0, c1})
		issue(3'h4, 2'h0);
		`CHK(s, 8'h01)
		u_host.setup(12'h123, 4'h0, s);
		issue(3'h3, m);
		`CHK({wr_ready, ch_write_gate, ch_read_gate}, 3'h1)
		@(posedge ref_clk);
		ch0_rd_valid <= 1'b1;
		ch1_rd_valid <= 1'b1;
		ch0_rd_data <= c0;
		ch1_rd_data <= c1;
		@(posedge ref_clk);
		ch0_rd_valid <= 1'b0;
		ch1_rd_valid <= 1'b0;
		ch0_rd_data <= ~c0;
		ch1_rd_data <= ~c1;
		#1 `CHK({rd_valid, rd_data}, {1'b1, w0})
		@(posedge ref_clk);
		#1 `CHK({rd_valid, rd_data}, {1'b1, w1})
		issue(3'h4, 2'h0);
		`CHK(s, 8'h01)
		$display("test mode %0d over", m);
	endtask
	task t_errors;
		u_host.setup(12'h045, 4'h0, s);
		issue(3'h2, 2'h2);
		u_host.single(16'hC3A5);
		issue(3'h4, 2'h0);
		`CHK({s, ch_wr_valid, ch0_wr_data, ch1_wr_data, wr_ready}, {8'h40, 1'b1, 16'hC3A5, 16'h0000, 1'b0})
		u_host.setup(12'h045, 4'h0, s);
		issue(3'h3, 2'h2);
		@(posedge ref_clk);
		ch0_rd_valid <= 1'b1;
		@(posedge ref_clk);
		ch0_rd_valid <= 1'b0;
		#1 `CHK(rd_valid, 1'b0)
		issue(3'h4, 2'h0);
		`CHK({s, ch_read_gate}, {8'h08, 1'b0})
		$display("test errors over");
	endtask
	task t_track;
		int n;
		n = 0;
		@(posedge ref_clk);
		index_pin <= 1'b1;
		repeat (10) @(posedge ref_clk) #1 n += track_start;
		index_pin <= 1'b0;
		`CHK(n, 1)
		$display("test track over");
	endtask
	task t_fault;
		int i;
		@(posedge ref_clk);
		fault_pin <= 1'b1;
		for (i = 0; i < 10 && fault_out !== 1'b1; i++)
			@(posedge ref_clk) #1;
		if (i == 10) begin
			fails++;
			final_report;
		end
		`CHK(fault_led, 1'b1)
		issue(3'h0, 2'h0);
		`CHK(s[5], 1'b1)
		@(posedge ref_clk);
		fault_pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		issue(3'h5, 2'h0);
		@(posedge ref_clk);
		#1 `CHK({fault_out, fault_led}, 2'h0)
		$display("test fault over");
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		rst = 1'b1;
		{ch0_rd_valid, ch1_rd_valid, index_pin, fault_pin} = 4'h0;
		{ch0_rd_data, ch1_rd_data} = 32'h0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_refuse;
		t_xfer(2'h0, 16'hAAAA, 16'h5555, 16'hFF00, 16'h00FF);
		t_xfer(2'h1, 16'h1234, 16'h5678, 16'h1256, 16'h3478);
		t_xfer(2'h2, 16'h1234, 16'h5678, 16'h1234, 16'h5678);
		t_errors;
		t_track;
		t_fault;
		final_report;
	end
endmodule
